//--- design/psp_regs.svh
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// Register byte offsets on the bus.
`define PSP_OFS_TASK_STOP 12'h004
`define PSP_OFS_TASK_BEGIN0 12'h008
`define PSP_OFS_TASK_BEGIN1 12'h00C
`define PSP_OFS_TASK_STEP 12'h010
`define PSP_OFS_EVT_STOPPED 12'h104
`define PSP_OFS_EVT_BEGAN0 12'h108
`define PSP_OFS_EVT_BEGAN1 12'h10C
`define PSP_OFS_EVT_FINISH0 12'h110
`define PSP_OFS_EVT_FINISH1 12'h114
`define PSP_OFS_EVT_PERIOD 12'h118
`define PSP_OFS_EVT_CHAIN 12'h11C
`define PSP_OFS_COUNT_MODE 12'h504
`define PSP_OFS_LIMIT 12'h508
`define PSP_OFS_PRESCALE 12'h50C
`define PSP_OFS_DECODER 12'h510
`define PSP_OFS_REPEAT 12'h514
`define PSP_OFS_SEQ0 12'h520
`define PSP_OFS_SEQ1 12'h540
`define PSP_OFS_PSEL0 12'h560
`define PSP_OFS_PSEL1 12'h564
`define PSP_OFS_PSEL2 12'h568
`define PSP_OFS_PSEL3 12'h56C

// Word offsets inside one sequence block.
`define PSP_SEQ_PTR 2'h0
`define PSP_SEQ_CNT 2'h1
`define PSP_SEQ_REFRESH 2'h2
`define PSP_SEQ_DELAY 2'h3

// Pending event bit positions.
`define PSP_EV_STOPPED 0
`define PSP_EV_BEGAN0 1
`define PSP_EV_BEGAN1 2
`define PSP_EV_FINISH0 3
`define PSP_EV_FINISH1 4
`define PSP_EV_PERIOD 5
`define PSP_EV_CHAIN 6
`define PSP_EV_NUM 7

// Field positions, widths, codes and reset values.
`define PSP_DEC_LOAD_LSB 0
`define PSP_DEC_STEP_BIT 8
`define PSP_LOAD_WAVE 2'h3
`define PSP_POL_BIT 15
`define PSP_CNT_W 15
`define PSP_DLY_W 24
`define PSP_LIMIT_W 15
`define PSP_PRE_W 3
`define PSP_REPEAT_W 16
`define PSP_PSEL_RESET 32'hFFFFFFFF
`define PSP_LIMIT_RESET 15'h03FF

`endif

//--- design/psp_pkg.sv
package psp_pkg;

	// One value fetched from memory: polarity on top, compare below.
	typedef struct packed {
		logic pol;
		logic [14:0] cmp;
	} psp_sample_t;

	// Settings of one sequence.
	typedef struct packed {
		logic [31:0] ptr;
		logic [14:0] cnt;
		logic [23:0] refresh;
		logic [23:0] delay;
	} psp_seq_cfg_t;

	// Playback states, one-hot.
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_FETCH = 7'h02,
		S_ARM = 7'h04,
		S_STEP = 7'h08,
		S_TAIL = 7'h10,
		S_HOLD = 7'h20,
		S_STOP = 7'h40
	} psp_state_t;

endpackage

//--- design/psp_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"

module psp_period_timer import psp_pkg::*; #(
	parameter int LIMIT_W = `PSP_LIMIT_W,
	parameter int PRE_W = `PSP_PRE_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic hold_limit,
	input wire logic [LIMIT_W-1:0] limit_in,
	input wire logic [PRE_W-1:0] prescale,
	output logic period_end
);

	initial begin
		if (LIMIT_W < 2 || PRE_W < 1 || PRE_W > 4) begin
			$error("psp_period_timer: unsupported widths");
		end
	end

	logic [15:0] div_cnt;
	logic tick;
	logic [LIMIT_W-1:0] count;
	logic [LIMIT_W-1:0] limit_act;

	// Prescaler: one-cycle enable every 2**prescale clocks.
	assign tick = ((div_cnt & ((16'h0001 << prescale) - 16'h0001)) == 16'h0000);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 16'h0000;
		end else if (!run) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// Wave counter; a period ends when the count reaches the applied limit.
	assign period_end = run && tick && (count >= limit_act);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (!run || period_end) begin
			count <= '0;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			limit_act <= `PSP_LIMIT_RESET;
		end else if (!hold_limit && (!run || period_end)) begin
			limit_act <= limit_in;
		end
	end

	AST_LIMIT_AT_PERIOD_END: assert property (@(posedge ref_clk) disable iff (rst)
		(run && !period_end) |=> $stable(limit_act))
		else $error("counter limit changed inside a period");

endmodule // psp_period_timer

`default_nettype wire

//--- design/psp_playback.sv
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"

module psp_playback import psp_pkg::*; #(
	parameter int REPEAT_W = `PSP_REPEAT_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic dma_req,
	output logic [31:0] dma_addr,
	input wire logic dma_ack,
	input wire logic [15:0] dma_data,
	output psp_sample_t cmp_out,
	output logic gen_running,
	output logic [31:0] count_mode,
	output logic [`PSP_PRE_W-1:0] prescale,
	output logic [3:0][31:0] pin_select,
	output logic [`PSP_EV_NUM-1:0] event_pulse
);

	initial begin
		if (REPEAT_W < 1 || REPEAT_W > 32) begin
			$error("psp_playback: REPEAT_W out of range");
		end
	end

	// Byte-lane merge of a bus write into a stored word.
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave and registers

	logic acc;
	logic wr;
	logic [31:0] decoder;
	logic [`PSP_LIMIT_W-1:0] limit;
	logic [REPEAT_W-1:0] repeat_cnt;
	psp_seq_cfg_t seq_cfg [2];
	logic [`PSP_EV_NUM-1:0] ev_pend;
	logic task_stop;
	logic task_step;
	logic [1:0] task_begin;
	logic step_mode;
	logic wave_mode;

	// A request is taken on its first cycle; ack follows one cycle later.
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i;
	assign step_mode = decoder[`PSP_DEC_STEP_BIT];
	assign wave_mode = (decoder[`PSP_DEC_LOAD_LSB +: 2] == `PSP_LOAD_WAVE);

	assign task_stop = wr && (wb_adr_i == `PSP_OFS_TASK_STOP) && wb_dat_i[0];
	assign task_step = wr && (wb_adr_i == `PSP_OFS_TASK_STEP) && wb_dat_i[0];
	assign task_begin[0] = wr && (wb_adr_i == `PSP_OFS_TASK_BEGIN0) && wb_dat_i[0];
	assign task_begin[1] = wr && (wb_adr_i == `PSP_OFS_TASK_BEGIN1) && wb_dat_i[0];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= acc;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_mode <= 32'h00000000;
			decoder <= 32'h00000000;
			limit <= `PSP_LIMIT_RESET;
			prescale <= '0;
			repeat_cnt <= '0;
			pin_select <= {4{`PSP_PSEL_RESET}};
		end else if (wr) begin
			case (wb_adr_i)
				`PSP_OFS_COUNT_MODE: count_mode <= wb_merge(count_mode, wb_dat_i, wb_sel_i);
				`PSP_OFS_DECODER: decoder <= wb_merge(decoder, wb_dat_i, wb_sel_i);
				`PSP_OFS_LIMIT: limit <= wb_dat_i[`PSP_LIMIT_W-1:0];
				`PSP_OFS_PRESCALE: prescale <= wb_dat_i[`PSP_PRE_W-1:0];
				`PSP_OFS_REPEAT: repeat_cnt <= wb_dat_i[REPEAT_W-1:0];
				`PSP_OFS_PSEL0: pin_select[0] <= wb_merge(pin_select[0], wb_dat_i, wb_sel_i);
				`PSP_OFS_PSEL1: pin_select[1] <= wb_merge(pin_select[1], wb_dat_i, wb_sel_i);
				`PSP_OFS_PSEL2: pin_select[2] <= wb_merge(pin_select[2], wb_dat_i, wb_sel_i);
				`PSP_OFS_PSEL3: pin_select[3] <= wb_merge(pin_select[3], wb_dat_i, wb_sel_i);
				default: begin
				end
			endcase
		end
	end

	// Sequence settings; only storage here, playback samples them itself.
	for (genvar n = 0; n < 2; n++) begin : g_seq
		localparam logic [11:0] BASE = (n == 0) ? `PSP_OFS_SEQ0 : `PSP_OFS_SEQ1;
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				seq_cfg[n] <= '0;
			end else if (wr && wb_adr_i[11:4] == BASE[11:4]) begin
				case (wb_adr_i[3:2])
					`PSP_SEQ_PTR: seq_cfg[n].ptr <= wb_merge(seq_cfg[n].ptr, wb_dat_i, wb_sel_i);
					`PSP_SEQ_CNT: seq_cfg[n].cnt <= wb_dat_i[`PSP_CNT_W-1:0];
					`PSP_SEQ_REFRESH: seq_cfg[n].refresh <= wb_dat_i[`PSP_DLY_W-1:0];
					default: seq_cfg[n].delay <= wb_dat_i[`PSP_DLY_W-1:0];
				endcase
			end
		end
	end

	// Read mux; unmapped addresses read zero and are still acknowledged.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h00000000;
		end else if (acc) begin
			case (wb_adr_i)
				`PSP_OFS_EVT_STOPPED: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_STOPPED]};
				`PSP_OFS_EVT_BEGAN0: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_BEGAN0]};
				`PSP_OFS_EVT_BEGAN1: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_BEGAN1]};
				`PSP_OFS_EVT_FINISH0: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_FINISH0]};
				`PSP_OFS_EVT_FINISH1: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_FINISH1]};
				`PSP_OFS_EVT_PERIOD: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_PERIOD]};
				`PSP_OFS_EVT_CHAIN: wb_dat_o <= {31'h0, ev_pend[`PSP_EV_CHAIN]};
				`PSP_OFS_COUNT_MODE: wb_dat_o <= count_mode;
				`PSP_OFS_DECODER: wb_dat_o <= decoder;
				`PSP_OFS_LIMIT: wb_dat_o <= {{(32-`PSP_LIMIT_W){1'b0}}, limit};
				`PSP_OFS_PRESCALE: wb_dat_o <= {{(32-`PSP_PRE_W){1'b0}}, prescale};
				`PSP_OFS_REPEAT: wb_dat_o <= {{(32-REPEAT_W){1'b0}}, repeat_cnt};
				`PSP_OFS_PSEL0: wb_dat_o <= pin_select[0];
				`PSP_OFS_PSEL1: wb_dat_o <= pin_select[1];
				`PSP_OFS_PSEL2: wb_dat_o <= pin_select[2];
				`PSP_OFS_PSEL3: wb_dat_o <= pin_select[3];
				`PSP_OFS_SEQ0: wb_dat_o <= seq_cfg[0].ptr;
				`PSP_OFS_SEQ1: wb_dat_o <= seq_cfg[1].ptr;
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	for (genvar e = 0; e < `PSP_EV_NUM; e++) begin : g_ev
		localparam logic [11:0] EOFS = `PSP_OFS_EVT_STOPPED + 12'(e * 4);
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				ev_pend[e] <= 1'b0;
			end else if (event_pulse[e]) begin
				ev_pend[e] <= 1'b1;
			end else if (wr && wb_adr_i == EOFS && !wb_dat_i[0]) begin
				ev_pend[e] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Playback sequencer

	psp_state_t state;
	psp_state_t next_state;
	psp_seq_cfg_t cur;
	logic cur_seq;
	logic [`PSP_CNT_W-1:0] idx;
	logic [`PSP_DLY_W:0] dwell;
	logic [REPEAT_W-1:0] loops_left;
	psp_sample_t buf_val;
	logic first_val;
	logic period_end;
	logic apply;
	logic last;
	logic load_now;
	logic load_sel;
	logic done;
	logic stop_done;

	psp_period_timer u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(gen_running),
		.hold_limit(wave_mode),
		.limit_in(limit),
		.prescale(prescale),
		.period_end(period_end)
	);

	assign apply = (state == S_ARM) && (!gen_running || (period_end && dwell == '0));
	assign last = (idx == cur.cnt - 1'b1);
	assign stop_done = (state == S_STOP) && (!gen_running || period_end);
	assign done = (state == S_TAIL) && (dwell == '0) && cur_seq && (loops_left <= 1);
	assign load_now = !task_stop && ((|task_begin) ||
		((state == S_TAIL) && (dwell == '0) && !done));
	assign load_sel = (|task_begin) ? task_begin[1] : !cur_seq;
	assign dma_req = (state == S_FETCH);
	assign dma_addr = cur.ptr + {16'h0000, idx, 1'b0};

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: next_state = S_IDLE;
			S_FETCH: if (dma_ack) next_state = S_ARM;
			S_ARM: begin
				if (apply) begin
					if (last) begin
						next_state = (repeat_cnt != '0) ? S_TAIL : S_HOLD;
					end else begin
						next_state = step_mode ? S_STEP : S_FETCH;
					end
				end
			end
			S_STEP: if (task_step) next_state = S_FETCH;
			S_TAIL: if (done) next_state = S_HOLD;
			S_HOLD: next_state = S_HOLD;
			S_STOP: if (stop_done) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
		if (task_stop && state != S_IDLE) begin
			next_state = S_STOP;
		end else if (load_now) begin
			next_state = S_FETCH;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
			cur_seq <= 1'b0;
		end else if (load_now) begin
			cur <= seq_cfg[load_sel];
			cur_seq <= load_sel;
		end else if (apply) begin
			cur.refresh <= seq_cfg[cur_seq].refresh;
			cur.delay <= seq_cfg[cur_seq].delay;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loops_left <= '0;
		end else if (|task_begin) begin
			loops_left <= repeat_cnt;
		end else if (load_now && cur_seq) begin
			loops_left <= loops_left - 1'b1;
		end
	end

	// Value index and the fetch buffer.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idx <= '0;
			buf_val <= '0;
			first_val <= 1'b0;
		end else begin
			if (load_now) begin
				idx <= '0;
				first_val <= 1'b1;
			end else if (apply) begin
				first_val <= 1'b0;
				if (!last) begin
					idx <= idx + 1'b1;
				end
			end
			if (dma_req && dma_ack) begin
				buf_val <= psp_sample_t'(dma_data);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dwell <= '0;
		end else if (apply) begin
			if (step_mode) begin
				dwell <= '0;
			end else if (last) begin
				dwell <= {1'b0, seq_cfg[cur_seq].refresh} + {1'b0, seq_cfg[cur_seq].delay};
			end else begin
				dwell <= {1'b0, seq_cfg[cur_seq].refresh};
			end
		end else if (period_end && dwell != '0 && state != S_HOLD) begin
			dwell <= dwell - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_out <= '0;
			gen_running <= 1'b0;
		end else if (stop_done) begin
			cmp_out <= '0;
			gen_running <= 1'b0;
		end else if (apply) begin
			cmp_out <= buf_val;
			gen_running <= 1'b1;
		end
	end

	always_comb begin
		event_pulse = '0;
		event_pulse[`PSP_EV_STOPPED] = stop_done;
		event_pulse[`PSP_EV_BEGAN0] = apply && first_val && !cur_seq;
		event_pulse[`PSP_EV_BEGAN1] = apply && first_val && cur_seq;
		event_pulse[`PSP_EV_FINISH0] = apply && last && !cur_seq;
		event_pulse[`PSP_EV_FINISH1] = apply && last && cur_seq;
		event_pulse[`PSP_EV_PERIOD] = period_end;
		event_pulse[`PSP_EV_CHAIN] = done;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_CAPTURE_PTR: assert property (load_now |=> cur.ptr == $past(seq_cfg[load_sel].ptr))
		else $error("pointer not captured at begin");
	AST_RESAMPLE: assert property ((apply && !load_now) |=>
		cur.delay == $past(seq_cfg[cur_seq].delay))
		else $error("tail delay not resampled on apply");
	AST_REFRESH_DWELL: assert property ((apply && !step_mode && !last) |=>
		dwell == {1'b0, $past(seq_cfg[cur_seq].refresh)})
		else $error("dwell does not match refresh count");
	AST_REPEAT_PREV: assert property ((period_end && !apply && !stop_done) |=>
		$stable(cmp_out))
		else $error("compare changed without a fetched value");
	AST_BEGAN_OUT: assert property ((event_pulse[`PSP_EV_BEGAN0] || event_pulse[`PSP_EV_BEGAN1])
		|=> gen_running && cmp_out == $past(buf_val))
		else $error("began event without value executing");
	AST_CHAIN_END_SEQ1: assert property (event_pulse[`PSP_EV_CHAIN] |-> cur_seq ##1
		state == S_HOLD)
		else $error("chain completed outside sequence one");
	AST_HOLD_LAST: assert property ((state == S_HOLD && !task_stop && !(|task_begin)) [*2]
		|-> $stable(cmp_out))
		else $error("held value changed");
	AST_STEP_WAIT: assert property ((state == S_STEP && !task_step && !task_stop &&
		!(|task_begin)) |=> state == S_STEP)
		else $error("step mode advanced without step task");
	AST_IDLE_LOW: assert property ((state == S_IDLE) |-> (!gen_running && cmp_out == '0))
		else $error("idle with active output");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule // psp_playback

`default_nettype wire

//--- bench/psp_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module psp_ram_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] lat,
	input wire logic dma_req,
	input wire logic [31:0] dma_addr,
	output logic dma_ack,
	output logic [15:0] dma_data
);
	logic [7:0] wait_n;

	////////////////////////////////////////////////////////////////////////////////
	// Answers each fetch after lat idle cycles, so slow memory can be mimicked.
	// Between answers the data bus toggles every cycle, so a stale read cannot pass.
	// Half word layout.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dma_ack <= 1'b0;
			dma_data <= 16'h0000;
			wait_n <= 8'h00;
		end else if (dma_req && !dma_ack && wait_n >= lat) begin
			dma_ack <= 1'b1;
			dma_data <= {dma_addr[2], dma_addr[15:1]};
			wait_n <= 8'h00;
		end else begin
			dma_ack <= 1'b0;
			dma_data <= ~dma_data;
			wait_n <= dma_req ? wait_n + 8'h01 : 8'h00;
		end
	end
endmodule // psp_ram_model

`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"

module testbench import psp_pkg::*;;
	logic ref_clk, rst, cyc, stb, we, wb_ack, dma_req, dma_ack, gen_running;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, wb_dat_o, dma_addr, count_mode;
	logic [15:0] dma_data;
	logic [7:0] lat;
	logic [2:0] prescale;
	logic [3:0][31:0] pin_select;
	logic [6:0] event_pulse;
	psp_sample_t cmp_out, last;
	int error_cnt, check_count, cyc_n;
	int ev_cnt[7];
	logic [31:0] addr_q[$];
	logic [15:0] val_q[$];
	int tim_q[$];

	psp_playback dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack), .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack),
		.dma_data(dma_data), .cmp_out(cmp_out), .gen_running(gen_running),
		.count_mode(count_mode), .prescale(prescale), .pin_select(pin_select),
		.event_pulse(event_pulse));
	psp_ram_model ram_u (.ref_clk(ref_clk), .rst(rst), .lat(lat), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_ack(dma_ack), .dma_data(dma_data));

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Logs fetch addresses, applied values with their cycle and event pulses.
	always @(posedge ref_clk) begin
		cyc_n++;
		if (dma_req && dma_ack) addr_q.push_back(dma_addr);
		if (cmp_out !== last) begin
			val_q.push_back(cmp_out);
			tim_q.push_back(cyc_n);
		end
		last = cmp_out;
		for (int i = 0; i < 7; i++) if (event_pulse[i] === 1'b1) ev_cnt[i]++;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] ram(input logic [31:0] a);
		return {16'h0000, a[2], a[15:1]};
	endfunction

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task conclude;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One classic cycle; the request stands until ack is seen at an edge.
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 64);
		// A bus that never answers counts as a mismatch.
		if (wb_ack !== 1'b1) chk(32'h1, 32'h0);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wait_ev(input int b, input int target);
		int n;
		n = 0;
		while (ev_cnt[b] < target && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 4000) chk(target, ev_cnt[b]);
	endtask

	task automatic cfg(input logic [11:0] b, input logic [31:0] p, c, r, d);
		wb(1'b1, b, p);
		wb(1'b1, b + 12'h004, c);
		wb(1'b1, b + 12'h008, r);
		wb(1'b1, b + 12'h00C, d);
	endtask

	task automatic clear;
		addr_q.delete();
		val_q.delete();
		tim_q.delete();
		foreach (ev_cnt[i]) ev_cnt[i] = 0;
	endtask

	// Halting must blank the output and stop the wave counter.
	task automatic halt;
		ev_cnt[`PSP_EV_STOPPED] = 0;
		wb(1'b1, `PSP_OFS_TASK_STOP, 32'h1);
		wait_ev(`PSP_EV_STOPPED, 1);
		tick(2);
		chk(32'h0, {15'h0, gen_running, cmp_out}); // halt ends hold.
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(32'h0, {14'h0, gen_running, dma_req, cmp_out}); // idle after reset.
		wb(1'b0, `PSP_OFS_LIMIT, 32'h0);
		chk(32'h3FF, rdat);
		wb(1'b0, 12'h7F0, 32'h0);
		chk(32'h0, rdat);
		wb(1'b1, `PSP_OFS_PSEL1, 32'h5);
		chk(32'h5, pin_select[1]); // immediate pin select.
		wb(1'b1, `PSP_OFS_PRESCALE, 32'h3);
		chk(32'h3, {29'h0, prescale}); // immediate prescaler.
		wb(1'b1, `PSP_OFS_COUNT_MODE, 32'h1);
		chk(32'h1, count_mode); // immediate mode.
		wb(1'b1, `PSP_OFS_PRESCALE, 32'h0);
		wb(1'b1, `PSP_OFS_COUNT_MODE, 32'h0);
		wb(1'b1, `PSP_OFS_LIMIT, 32'h9);
	endtask

	task automatic t_single;
		clear();
		cfg(`PSP_OFS_SEQ0, 32'h1000, 32'h3, 32'h1, 32'h0);
		wb(1'b1, `PSP_OFS_REPEAT, 32'h0);
		wb(1'b1, `PSP_OFS_TASK_BEGIN0, 32'h1);
		wait_ev(`PSP_EV_BEGAN0, 1);
		wb(1'b1, `PSP_OFS_SEQ0, 32'h2000);
		wait_ev(`PSP_EV_FINISH0, 1);
		// Refresh rewritten only after the last fetch.
		wb(1'b1, `PSP_OFS_SEQ0 + 12'h008, 32'h1);
		tick(60);
		chk(32'h3, addr_q.size()); // single pass.
		for (int i = 0; i < 3 && i < addr_q.size(); i++) begin
			chk(32'h1000 + 2 * i, addr_q[i]); // pointer captured.
			chk(ram(32'h1000 + 2 * i), val_q[i]); // value layout.
		end
		chk(32'd20, tim_q[2] - tim_q[1]); // refresh spacing.
		chk(ram(32'h1004), cmp_out); // last value held.
		chk(32'h1, ev_cnt[`PSP_EV_BEGAN0]); // began once.
		chk(32'h1, ev_cnt[`PSP_EV_PERIOD] > 0); // period events pulse.
		wb(1'b0, `PSP_OFS_EVT_BEGAN0, 32'h0);
		chk(32'h1, rdat & 32'h1); // pending flag.
		wb(1'b1, `PSP_OFS_EVT_BEGAN0, 32'h0);
		wb(1'b0, `PSP_OFS_EVT_BEGAN0, 32'h0);
		chk(32'h0, rdat & 32'h1); // flag cleared.
		halt();
	endtask

	task automatic t_chain(input logic s1);
		logic [31:0] exp[4];
		exp = '{32'h1000, 32'h1002, 32'h3000, 32'h3002};
		clear();
		cfg(`PSP_OFS_SEQ0, 32'h1000, 32'h2, 32'h0, 32'h1);
		cfg(`PSP_OFS_SEQ1, 32'h3000, 32'h2, 32'h0, 32'h0);
		wb(1'b1, `PSP_OFS_REPEAT, 32'h1);
		wb(1'b1, s1 ? `PSP_OFS_TASK_BEGIN1 : `PSP_OFS_TASK_BEGIN0, 32'h1);
		wait_ev(`PSP_EV_CHAIN, 1);
		tick(60);
		chk(32'h1, ev_cnt[`PSP_EV_CHAIN]); // chain complete.
		chk(32'h1, ev_cnt[`PSP_EV_FINISH1]); // last finish.
		chk(ram(32'h3002), cmp_out); // hold after chain.
		if (s1) begin
			chk(32'h3000, addr_q[0]); // starts at begun sequence.
		end else begin
			chk(32'h4, addr_q.size()); // one chained pass.
			for (int i = 0; i < 4 && i < addr_q.size(); i++) chk(exp[i], addr_q[i]);
			chk(32'd10, tim_q[1] - tim_q[0]); // one period each.
			chk(32'd20, tim_q[2] - tim_q[1]); // tail delay.
			chk(32'h1, ev_cnt[`PSP_EV_FINISH0]); // first finish.
		end
		wb(1'b1, `PSP_OFS_REPEAT, 32'h0);
		halt();
	endtask

	task automatic t_step;
		clear();
		wb(1'b1, `PSP_OFS_DECODER, 32'h100);
		cfg(`PSP_OFS_SEQ0, 32'h1000, 32'h3, 32'h0, 32'h5);
		wb(1'b1, `PSP_OFS_TASK_BEGIN0, 32'h1);
		wait_ev(`PSP_EV_BEGAN0, 1);
		tick(100);
		chk(32'h1, val_q.size()); // no timed advance.
		wb(1'b1, `PSP_OFS_TASK_STEP, 32'h1);
		tick(40);
		chk(32'h2, val_q.size()); // one step.
		chk(ram(32'h1002), cmp_out); // next value.
		halt();
		wb(1'b1, `PSP_OFS_DECODER, 32'h0);
	endtask

	// Memory slower than a period: old compare repeats until new value lands.
	task automatic t_slow;
		clear();
		lat <= 8'd30;
		cfg(`PSP_OFS_SEQ0, 32'h1000, 32'h3, 32'h0, 32'h0);
		wb(1'b1, `PSP_OFS_TASK_BEGIN0, 32'h1);
		wait_ev(`PSP_EV_FINISH0, 1);
		tick(60);
		chk(32'h3, val_q.size()); // no glitch values.
		for (int i = 1; i < 3 && i < val_q.size(); i++) begin
			chk(ram(32'h1000 + 2 * i), val_q[i]); // fetched values only.
			chk(32'h0, (tim_q[i] - tim_q[0]) % 10); // period boundary.
		end
		chk(32'h1, tim_q[1] - tim_q[0] > 10); // value repeated.
		lat <= 8'd0;
		halt();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the expected run of about a thousand cycles.
	initial begin
		repeat (40000) @(posedge ref_clk);
		chk(32'h1, 32'h0);
		conclude();
	end

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 12'h000;
		wdat = 32'h0;
		lat = 8'd0;
		last = '0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_single();
		t_chain(1'b0);
		t_chain(1'b1);
		t_step();
		t_slow();
		conclude();
	end
endmodule // testbench

`default_nettype wire
